// ### tb_top.sv
/* tb_top: self-checking bench for tdcr_regs with the tool model.
   assumes: 100 MHz mclk, reads answered one cycle after the strobe. */
`timescale 1ns/1ps
module tb_top;
  import tdcr_pkg::*;
  logic mclk, reset_n, reg_access, reg_write, reg_rvalid, reg_error, debug_entry, event_in_n;
  logic [6:0] reg_num;
  logic [31:0] reg_wdata, reg_rdata, d, m;
  logic [21:0] wp_hit;
  logic [5:0] trig_start, trig_stop, trace_type_enables;
  logic [2:0] wp_event_out;
  logic event_out_n;
  logic trace_sync_req, debug_req;
  logic [32:0] q[$];
  int fail_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed, i;
  int wl[7] = '{3, 14, 5, 21, 16, 15, 17};
  logic [3:0] el[7] = '{4'h9, 4'h5, 4'h0, 4'h3, 4'h0, 4'h1, 4'h1};
  tdcr_tool tdcr_tool_i(.mclk(mclk), .reg_access(reg_access), .reg_write(reg_write),
    .reg_num(reg_num), .reg_wdata(reg_wdata));
  tdcr_regs tdcr_regs_i(.mclk(mclk), .reset_n(reset_n), .reg_access(reg_access),
    .reg_write(reg_write), .reg_num(reg_num), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_error(reg_error), .wp_hit(wp_hit), .trig_start(trig_start),
    .trig_stop(trig_stop), .debug_entry(debug_entry), .event_in_n(event_in_n),
    .port_width_select(), .trace_clock_divide(), .trace_clk(), .trace_clk_en(),
    .program_trace_method(), .periodic_owner_trace_off(), .periodic_owner_event_en(),
    .trace_type_enables(trace_type_enables), .trace_sync_req(trace_sync_req),
    .debug_req(debug_req),
    .wp_event_out(wp_event_out), .event_out_n(event_out_n));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic give_verdict;
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [6:0] n, input logic [32:0] e);
    q.push_back(e);
    tdcr_tool_i.acc(1'b0, n, 32'h0000_0000);
  endtask : rd
  task automatic pulse_dbg;
    @(posedge mclk);
    #1 debug_entry = 1'b1;
    @(posedge mclk);
    #1 debug_entry = 1'b0;
  endtask : pulse_dbg
  task automatic hit(input int w, input logic [3:0] e);
    @(posedge mclk);
    #1 wp_hit = 22'h00_0001 << w;
    @(posedge mclk);
    #1 wp_hit = 22'h00_0000;
    chk({29'h0, wp_event_out, event_out_n}, {29'h0, e});
  endtask : hit
  // ====================================================================
  // monitor: oldest note against each answer
  always @(negedge mclk) begin
    if (reg_rvalid === 1'b1 || reg_error === 1'b1) begin
      if (q.size() == 0) chk({reg_error, reg_rdata}, 33'h1_FFFF_FFFF);
      else chk({reg_error, reg_rdata}, q.pop_front());
    end
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      give_verdict();
    end
  end
  // ====================================================================
  // main sequence
  initial begin
    seed = 39522;
    {reset_n, debug_entry, wp_hit, trig_start, trig_stop} = '0;
    event_in_n = 1'b1;
    repeat (20) @(posedge mclk);
    #1 reset_n = 1'b1;
    for (i = 2; i < 5; i++) rd(7'(i), 33'h0_0000_0000);
    rd(7'h05, 33'h1_0000_0000);
    pulse_dbg();
    tdcr_tool_i.acc(1'b1, 7'h02, 32'hE000_0000);
    rd(7'h02, 33'h0_E000_0000);
    tdcr_tool_i.gap = 2;
    for (i = 0; i < 9; i++) begin
      d = $random(seed);
      if (i % 3 == 0) d = (d & 32'h1FFF_CFFF) | 32'hE000_0000;
      m = (i % 3 == 0) ? 32'hE800_4F2F : (i % 3 == 1) ? 32'h0FFF_FFFF : 32'h0FFF_003F;
      tdcr_tool_i.acc(1'b1, 7'(2 + i % 3), d);
      rd(7'(2 + i % 3), {1'b0, d & m});
    end
    tdcr_tool_i.gap = 0;
    q.push_back(33'h1_0000_0000);
    tdcr_tool_i.acc(1'b1, 7'h7F, 32'hFFFF_FFFF);
    repeat (40) begin
      @(posedge mclk);
      #1 trig_start = 6'($random(seed));
      trig_stop = 6'($random(seed));
      wp_hit = 22'($random(seed));
      event_in_n = 1'($random(seed));
    end
    @(posedge mclk);
    #1 {wp_hit, trig_start, trig_stop} = '0;
    event_in_n = 1'b1;
    // start triggers collide with the write edge
    fork
      tdcr_tool_i.acc(1'b1, 7'h02, 32'hE000_0000);
      begin
        @(posedge mclk);
        #1 trig_start = 6'h2F;
        @(posedge mclk);
        #1 trig_start = 6'h00;
      end
    join
    rd(7'h02, 33'h0_E000_0000);
    tdcr_tool_i.acc(1'b1, 7'h03, 32'h04F0_0020);
    tdcr_tool_i.acc(1'b1, 7'h04, 32'h0807_0001);
    for (i = 0; i < 7; i++) hit(wl[i], el[i]);
    tdcr_tool_i.acc(1'b1, 7'h02, 32'hE000_0400);
    hit(5, 4'h1);
    pulse_dbg();
    chk({32'h0, event_out_n}, 33'h0_0000_0000);
    // event-in as debug request, then as sync request
    tdcr_tool_i.acc(1'b1, 7'h02, 32'hE000_0100);
    @(posedge mclk);
    #1 event_in_n = 1'b0;
    #1 chk({31'h0, debug_req, trace_sync_req}, 33'h0_0000_0002);
    @(posedge mclk);
    #1 event_in_n = 1'b1;
    tdcr_tool_i.acc(1'b1, 7'h02, 32'hE000_0000);
    @(posedge mclk);
    #1 event_in_n = 1'b0;
    #1 chk({31'h0, debug_req, trace_sync_req}, 33'h0_0000_0001);
    @(posedge mclk);
    #2 chk({31'h0, debug_req, trace_sync_req}, 33'h0_0000_0000);
    repeat (3) @(posedge mclk);
    if (q.size() != 0) begin
      fail_count++;
      $display("[ERR] %0t expected answers never came", $time);
    end
    give_verdict();
  end
endmodule : tb_top

// ### tdcr_clkdiv.sv
/*
  tdcr_clkdiv: trace output clock from the processor clock, divide 1/2/4/8.
  assumes: divide code changes only in reset or debug mode.
*/
`timescale 1ns/1ps
module tdcr_clkdiv
  import tdcr_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [1:0] divide,
  output logic trace_clk_en,
  output logic trace_clk
);
  // ====================================================================
  // divider counter
  logic [2:0] count_r;
  logic [2:0] count_nxt;
  logic [2:0] terminal;
  logic phase_r;
  logic wrap;
  tdcr_div_e div_sel;

  assign div_sel = tdcr_div_e'(divide);
  assign terminal = (div_sel == TDCR_DIV2) ? 3'h0 :
                    (div_sel == TDCR_DIV4) ? 3'h1 :
                    (div_sel == TDCR_DIV8) ? 3'h3 : 3'h0;
  assign wrap = (count_r >= terminal);
  assign count_nxt = wrap ? 3'h0 : 3'(count_r + 3'h1);
  assign trace_clk_en = (div_sel == TDCR_DIV1) ? 1'b1 : (wrap & phase_r);
  // divide by one passes the clock through
  assign trace_clk = (div_sel == TDCR_DIV1) ? mclk : phase_r; // RQ2

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= 3'h0;
      phase_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      if (wrap) begin
        phase_r <= ~phase_r; // RQ2
      end
    end
  end
endmodule : tdcr_clkdiv

// ### tdcr_pkg.sv
/*
  tdcr_pkg: register numbers, field positions, reset values and codes for
  the trace development control registers.
  assumes: used by tdcr_regs and tdcr_clkdiv on one processor clock.
*/
package tdcr_pkg;
  // ====================================================================
  // register numbers (debug register port access codes) and register reset value
  localparam logic [6:0] TDCR_REG_TRACE_PORT_CONTROL = 7'h02;
  localparam logic [6:0] TDCR_REG_WP_OUT_MAP_LOW = 7'h03;
  localparam logic [6:0] TDCR_REG_WP_OUT_MAP_HIGH = 7'h04;
  localparam logic [31:0] TDCR_RESET_VALUE = 32'h0000_0000;
  // ====================================================================
  // trace_port_control fields
  localparam int TDCR_PORT_WIDTH_BIT = 31;
  localparam int TDCR_CLKDIV_LSB = 29;
  localparam int TDCR_PTM_BIT = 27;
  localparam int TDCR_PERIODIC_OWNER_TRACE_OFF_BIT = 14;
  localparam int TDCR_TS_LSB = 12;
  localparam int TDCR_EVO_LSB = 10;
  localparam int TDCR_EVI_LSB = 8;
  localparam int TDCR_TT_LSB = 0;
  localparam logic [31:0] TDCR_TPC_WMASK = 32'hE800_4F3F;
  localparam logic [31:0] TDCR_MAPL_WMASK = 32'h0FFF_FFFF;
  localparam logic [31:0] TDCR_MAPH_WMASK = 32'h0FFF_003F;
  localparam logic [5:0] TDCR_TT_RESERVED = 6'h10;
  // ====================================================================
  // map register fields
  localparam int TDCR_WEV2_LSB = 24;
  localparam int TDCR_WEV1_LSB = 20;
  localparam int TDCR_WEV0_LSB = 16;
  localparam int TDCR_LOW_WP_COUNT = 15;
  localparam int TDCR_HIGH_WP_BASE = 15;
  localparam int TDCR_HIGH_WP_COUNT = 7;
  localparam int TDCR_WP_COUNT = 22;
  // ====================================================================
  // event pin codes and trace clock divide codes
  localparam logic [1:0] TDCR_EVO_WATCHPOINT = 2'h0;
  localparam logic [1:0] TDCR_EVO_DEBUG_ENTRY = 2'h1;
  localparam logic [1:0] TDCR_EVI_SYNC = 2'h0;
  localparam logic [1:0] TDCR_EVI_DEBUG_REQ = 2'h1;
  typedef enum logic [1:0] {
    TDCR_DIV1 = 2'b00,
    TDCR_DIV2 = 2'b01,
    TDCR_DIV4 = 2'b10,
    TDCR_DIV8 = 2'b11
  } tdcr_div_e;
endpackage : tdcr_pkg

// ### tdcr_regs.sv
/*
  tdcr_regs: three trace development control registers and the watchpoint
  to event pin routing they configure.
  assumes: register port gives a one-cycle strobe with register number and
  data; watchpoint hits are one-cycle pulses on mclk.
*/
// Behaviour
// RQ1 - bit 31 selects reduced or full port
// RQ2 - bits 30-29 divide trace clock 1/2/4/8
// RQ3 - bit 27 selects branch history messages
// RQ4 - bit 14 suppresses periodic ownership events
// RQ5 - timestamp field unimplemented, tool writes zero
// RQ6 - event-out source: watchpoints or debug entry
// RQ7 - event-in used as sync or debug request
// RQ8 - six trace-type enables, bit 4 reserved
// RQ9 - register write beats hardware trace-type update
// RQ10 - tool changes width/divide only reset/debug
// RQ11 - tool should change others only then
// RQ12 - register 0x2 read/write, resets zero
// RQ13 - low map selects watchpoint 0-14 for out2
// RQ14 - low map fields select out1, out0
// RQ15 - low mask routes watchpoints 0-15 event-out
// RQ16 - masks act only in watchpoint event-out mode
// RQ17 - high map codes 1-7 select watchpoints 15-21
// RQ18 - high mask routes watchpoints 16-21 event-out
// RQ19 - register 0x3 read/write, resets zero
// RQ20 - start trigger sets, stop clears enables
// RQ21 - access through the test port register mechanism
// RQ22 - outputs assert on selected or masked watchpoints
// RQ23 - reserved bits read zero, ignore writes
`timescale 1ns/1ps
module tdcr_regs
  import tdcr_pkg::*;
#(
  parameter int WP_COUNT = TDCR_WP_COUNT
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic reg_access,
  input wire logic reg_write,
  input wire logic [6:0] reg_num,
  input wire logic [31:0] reg_wdata,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_error,
  input wire logic [WP_COUNT-1:0] wp_hit,
  input wire logic [5:0] trig_start,
  input wire logic [5:0] trig_stop,
  input wire logic debug_entry,
  input wire logic event_in_n,
  output logic port_width_select,
  output logic [1:0] trace_clock_divide,
  output logic trace_clk,
  output logic trace_clk_en,
  output logic program_trace_method,
  output logic periodic_owner_trace_off,
  output logic periodic_owner_event_en,
  output logic [5:0] trace_type_enables,
  output logic trace_sync_req,
  output logic debug_req,
  output logic [2:0] wp_event_out,
  output logic event_out_n
);
  // ====================================================================
  // field decoders
  function automatic logic [WP_COUNT-1:0] low_select(input logic [3:0] code);
    logic [WP_COUNT-1:0] v;
    v = '0;
    if (code != 4'h0) begin
      v[code - 4'h1] = 1'b1; // RQ13
    end
    return v;
  endfunction : low_select

  function automatic logic [WP_COUNT-1:0] high_select(input logic [3:0] code);
    logic [WP_COUNT-1:0] v;
    v = '0;
    if ((code != 4'h0) && !code[3]) begin
      v[TDCR_HIGH_WP_BASE + int'(code) - 1] = 1'b1; // RQ17
    end
    return v;
  endfunction : high_select

  // ====================================================================
  // register port decode
  logic [31:0] tpc_r;
  logic [31:0] tpc_nxt;
  logic [31:0] mapl_r;
  logic [31:0] maph_r;
  logic [31:0] rdata_nxt;
  logic hit_tpc;
  logic hit_mapl;
  logic hit_maph;
  logic hit_any;
  logic wr_tpc;
  logic [5:0] tt_hw;
  logic [31:0] tpc_wr_val;

  // access through the test port register mechanism
  assign hit_tpc = (reg_num == TDCR_REG_TRACE_PORT_CONTROL); // RQ21
  assign hit_mapl = (reg_num == TDCR_REG_WP_OUT_MAP_LOW);
  assign hit_maph = (reg_num == TDCR_REG_WP_OUT_MAP_HIGH);
  assign hit_any = hit_tpc | hit_mapl | hit_maph;
  assign wr_tpc = reg_access & reg_write & hit_tpc;

  // timestamp and reserved bits masked off, read as zero
  assign tpc_wr_val = reg_wdata & TDCR_TPC_WMASK & ~{26'h000_0000, TDCR_TT_RESERVED}; // RQ5 RQ23

  // hardware trigger update: stop clears, start sets, both toggles
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_tt
      assign tt_hw[g] = (trig_start[g] & trig_stop[g]) ? ~tpc_r[TDCR_TT_LSB + g] :
                        trig_start[g] ? 1'b1 :
                        trig_stop[g] ? 1'b0 : tpc_r[TDCR_TT_LSB + g]; // RQ20
    end
  endgenerate

  // write wins over the hardware update in the same cycle
  assign tpc_nxt = wr_tpc ? tpc_wr_val :
                   {tpc_r[31:6], tt_hw & ~TDCR_TT_RESERVED}; // RQ9

  assign rdata_nxt = hit_tpc ? tpc_r :
                     hit_mapl ? mapl_r :
                     hit_maph ? maph_r : 32'h0000_0000;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tpc_r <= TDCR_RESET_VALUE; // RQ12
      mapl_r <= TDCR_RESET_VALUE; // RQ19
      maph_r <= TDCR_RESET_VALUE;
      reg_rdata <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
      reg_error <= 1'b0;
    end else begin
      tpc_r <= tpc_nxt; // RQ12
      if (reg_access && reg_write && hit_mapl) begin
        mapl_r <= reg_wdata & TDCR_MAPL_WMASK; // RQ19 RQ23
      end
      if (reg_access && reg_write && hit_maph) begin
        maph_r <= reg_wdata & TDCR_MAPH_WMASK; // RQ23
      end
      reg_rvalid <= reg_access & ~reg_write;
      reg_rdata <= (reg_access && !reg_write) ? rdata_nxt : 32'h0000_0000;
      reg_error <= reg_access & ~hit_any;
    end
  end

  // ====================================================================
  // control outputs
  assign port_width_select = tpc_r[TDCR_PORT_WIDTH_BIT]; // RQ1
  assign trace_clock_divide = tpc_r[TDCR_CLKDIV_LSB +: 2]; // RQ2
  assign program_trace_method = tpc_r[TDCR_PTM_BIT]; // RQ3
  assign periodic_owner_trace_off = tpc_r[TDCR_PERIODIC_OWNER_TRACE_OFF_BIT]; // RQ4
  assign periodic_owner_event_en = ~tpc_r[TDCR_PERIODIC_OWNER_TRACE_OFF_BIT] & tpc_r[TDCR_TT_LSB]; // RQ4
  assign trace_type_enables = tpc_r[TDCR_TT_LSB +: 6]; // RQ8

  logic [1:0] evo_ctl;
  logic [1:0] evi_ctl;
  logic evi_active;
  logic evi_prev_r;
  logic evi_fall;
  assign evo_ctl = tpc_r[TDCR_EVO_LSB +: 2];
  assign evi_ctl = tpc_r[TDCR_EVI_LSB +: 2];
  assign evi_active = ~event_in_n;
  assign evi_fall = evi_active & ~evi_prev_r;
  assign trace_sync_req = evi_fall & (evi_ctl == TDCR_EVI_SYNC); // RQ7
  assign debug_req = evi_active & (evi_ctl == TDCR_EVI_DEBUG_REQ); // RQ7

  tdcr_clkdiv u_clkdiv (
    .mclk(mclk),
    .reset_n(reset_n),
    .divide(trace_clock_divide),
    .trace_clk_en(trace_clk_en),
    .trace_clk(trace_clk)
  );

  // ====================================================================
  // watchpoint routing
  logic [WP_COUNT-1:0] sel2;
  logic [WP_COUNT-1:0] sel1;
  logic [WP_COUNT-1:0] sel0;
  logic [WP_COUNT-1:0] evo_mask;
  logic [2:0] wev_nxt;
  logic evo_wp;
  logic evo_nxt;

  assign sel2 = low_select(mapl_r[TDCR_WEV2_LSB +: 4]) |
                high_select(maph_r[TDCR_WEV2_LSB +: 4]); // RQ13 RQ17
  assign sel1 = low_select(mapl_r[TDCR_WEV1_LSB +: 4]) |
                high_select(maph_r[TDCR_WEV1_LSB +: 4]); // RQ14
  assign sel0 = low_select(mapl_r[TDCR_WEV0_LSB +: 4]) |
                high_select(maph_r[TDCR_WEV0_LSB +: 4]); // RQ14
  // low mask covers 0-15, high mask 16-21
  assign evo_mask = {maph_r[5:0], mapl_r[15:0]}; // RQ15 RQ18
  assign wev_nxt = {|(sel2 & wp_hit), |(sel1 & wp_hit), |(sel0 & wp_hit)}; // RQ22
  assign evo_wp = |(evo_mask & wp_hit); // RQ22
  assign evo_nxt = (evo_ctl == TDCR_EVO_WATCHPOINT) ? evo_wp : // RQ16 RQ6
                   (evo_ctl == TDCR_EVO_DEBUG_ENTRY) ? debug_entry : 1'b0; // RQ6

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wp_event_out <= 3'h0;
      event_out_n <= 1'b1;
      evi_prev_r <= 1'b0;
    end else begin
      wp_event_out <= wev_nxt; // RQ13
      event_out_n <= ~evo_nxt; // RQ6
      evi_prev_r <= evi_active;
    end
  end
endmodule : tdcr_regs

// ### tdcr_regs_sva.sv
/* tdcr_regs_sva: port checker for tdcr_regs.
   assumes: bound to tdcr_regs, one clock domain. */
`timescale 1ns/1ps
module tdcr_regs_sva(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic reg_access,
  input wire logic reg_write,
  input wire logic [6:0] reg_num,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_error,
  input wire logic [5:0] trig_start,
  input wire logic [5:0] trig_stop,
  input wire logic port_width_select,
  input wire logic [1:0] trace_clock_divide,
  input wire logic trace_clk_en,
  input wire logic periodic_owner_trace_off,
  input wire logic periodic_owner_event_en,
  input wire logic [5:0] trace_type_enables
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire known = reg_num >= 7'h02 && reg_num <= 7'h04;
  wire w2 = reg_access && reg_write && reg_num == 7'h02;
  sequence s_read;
    reg_access && !reg_write && known;
  endsequence
  a_read_answer: assert property (s_read |=> reg_rvalid && !reg_error)
    else $error("read not answered");
  a_bad_number: assert property (reg_access && !known |=>
    reg_error && (reg_rvalid != $past(reg_write)))
    else $error("unknown register not refused");
  a_write_wins: assert property (w2 |=>
    trace_type_enables == ($past(reg_wdata[5:0]) & 6'h2F))
    else $error("trace enables differ from write");
  a_port_fields: assert property (w2 |=>
    {port_width_select, trace_clock_divide} == $past(reg_wdata[31:29]))
    else $error("width or divide wrong");
  a_owner_event: assert property (
    periodic_owner_event_en == (!periodic_owner_trace_off && trace_type_enables[0]))
    else $error("owner event enable wrong");
  a_trig_start: assert property (
    !w2 && trig_start[0] && !trig_stop[0] |=> trace_type_enables[0])
    else $error("start trigger ignored");
  a_trig_stop: assert property (
    !w2 && trig_stop[0] && !trig_start[0] |=> !trace_type_enables[0])
    else $error("stop trigger ignored");
  a_tt_reserved: assert property (!trace_type_enables[4])
    else $error("reserved enable set");
  a_div1_clk: assert property (trace_clock_divide == 2'h0 |-> trace_clk_en)
    else $error("divide one not every cycle");
endmodule : tdcr_regs_sva
bind tdcr_regs tdcr_regs_sva tdcr_regs_sva_i(.*);

// ### tdcr_tool.sv
/* tdcr_tool: debug tool model driving the register port.
   assumes: one mclk domain, requests start just after a rising edge. */
`timescale 1ns/1ps
module tdcr_tool(
  input wire logic mclk,
  output logic reg_access,
  output logic reg_write,
  output logic [6:0] reg_num,
  output logic [31:0] reg_wdata
);
  int gap = 0;
  initial begin
    reg_access = 1'b0;
    reg_write = 1'b0;
    reg_num = 7'h00;
    reg_wdata = 32'h0000_0000;
  end
  // callers keep timestamp bits zero and touch width/divide only in debug
  task automatic acc(input logic wr, input logic [6:0] num,
                     input logic [31:0] d);
    repeat (gap) @(posedge mclk);
    @(posedge mclk);
    #1;
    reg_access = 1'b1;
    reg_write = wr;
    reg_num = num;
    reg_wdata = d;
    @(posedge mclk);
    #1;
    reg_access = 1'b0;
    reg_num = ~num;
    reg_wdata = ~d;
  endtask : acc
endmodule : tdcr_tool
